// ### upem_consts.svh
`ifndef UPEM_CONSTS_SVH
`define UPEM_CONSTS_SVH

// ****************************************************************
// Widths and counts
// ****************************************************************
`define UPEM_NCH        4
`define UPEM_SEL_W      2
`define UPEM_CNT_W      12
`define UPEM_CNT_ZERO   12'h000
`define UPEM_CNT_ONE    12'h001
`define UPEM_CNT_MAX    12'hfff
`define UPEM_NPKT       6
`define UPEM_NIRQ       5
`define UPEM_ADDR_W     5
`define UPEM_DATA_W     32
`define UPEM_BE_W       4

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define UPEM_OFS_CORR   5'h00
`define UPEM_OFS_UNC    5'h04
`define UPEM_OFS_SEL    5'h08
`define UPEM_OFS_HT     5'h0c
`define UPEM_OFS_FLAGS  5'h10
`define UPEM_OFS_IRQST  5'h14
`define UPEM_OFS_IRQMSK 5'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define UPEM_HT_OVF_BIT 12
`define UPEM_MB_BIT     2
`define UPEM_PKT_TRIG   0
`define UPEM_PKT_TACK   1
`define UPEM_PKT_STRM   2
`define UPEM_PKT_CACK   3
`define UPEM_PKT_LTST   4
`define UPEM_PKT_HBT    5
`define UPEM_IRQ_CORR   0
`define UPEM_IRQ_UNC    1
`define UPEM_IRQ_HT     2
`define UPEM_IRQ_OVF    3
`define UPEM_IRQ_PKT    4

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define UPEM_SEL_RST    2'h0
`define UPEM_MSK_RST    5'h00
`define UPEM_STS_RST    5'h00
`define UPEM_FLG_RST    6'h00
`define UPEM_RD_ZERO    32'h0000_0000
`define UPEM_RESP_OK    2'h0
`define UPEM_RESP_DEC   2'h3

`endif

// ### upem_pkg.sv
`include "upem_consts.svh"

package upem_pkg;

	// ****************************************************************
	// Event carriers
	// ****************************************************************
	typedef struct packed {
		logic                    ht_err;
		logic [`UPEM_NPKT-1:0]   pkt_err;
	} upem_chan_ev_s;

	typedef struct packed {
		logic corrected;
		logic uncorrected;
		logic multibyte;
	} upem_glob_ev_s;

	// ****************************************************************
	// Per-channel status
	// ****************************************************************
	typedef struct packed {
		logic                    ovf;
		logic [`UPEM_CNT_W-1:0]  cnt;
		logic [`UPEM_NPKT-1:0]   flags;
	} upem_chan_st_s;

	// Whole state of the top module
	typedef struct packed {
		logic [`UPEM_SEL_W-1:0]  sel;
		logic [`UPEM_NIRQ-1:0]   mask;
		logic [`UPEM_NIRQ-1:0]   status;
		logic [`UPEM_CNT_W-1:0]  corr_cnt;
		logic [`UPEM_CNT_W-1:0]  unc_cnt;
		logic                    mb_seen;
		logic                    ack;
		logic [`UPEM_DATA_W-1:0] rdata;
		logic [1:0]              resp;
	} upem_top_st_s;

	// Counter step, either wrapping or holding at full scale
	function automatic logic [`UPEM_CNT_W-1:0] upem_cnt_inc(
		input logic [`UPEM_CNT_W-1:0] c,
		input logic                   hold_at_max);
		if (hold_at_max && c == `UPEM_CNT_MAX) begin
			upem_cnt_inc = c;
		end else begin
			upem_cnt_inc = c + `UPEM_CNT_ONE;
		end
	endfunction

endpackage

// ### upem_chan.sv
`timescale 1ns/100ps
`include "upem_consts.svh"

module upem_chan
	import upem_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire logic          ce,
	input  wire upem_chan_ev_s ev,
	output upem_chan_st_s      st,
	output logic               ovf_evt,
	output logic               flag_evt
);

	upem_chan_st_s st_reg;
	upem_chan_st_s st_next;

	// ****************************************************************
	// Counter, overflow and sticky packet flags
	// ****************************************************************

	// Next state, no path clears anything
	always_comb begin
		st_next  = st_reg;
		ovf_evt  = 1'b0;
		flag_evt = 1'b0;
		if (ev.ht_err) begin
			st_next.cnt = upem_cnt_inc(st_reg.cnt, 1'b0); // see (R02) see (R14)
			if (st_reg.cnt == `UPEM_CNT_MAX) begin
				st_next.ovf = 1'b1;                       // see (R03) see (R14)
				ovf_evt     = 1'b1;
			end
		end
		// see (R05) see (R06) see (R07) see (R08) see (R09) see (R10)
		st_next.flags = st_reg.flags | ev.pkt_err;
		flag_evt      = |(ev.pkt_err & ~st_reg.flags);
	end

	// Register, frozen while clock enable is low
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_reg.ovf   <= 1'b0;
			st_reg.cnt   <= `UPEM_CNT_ZERO;
			st_reg.flags <= `UPEM_FLG_RST;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign st = st_reg;

endmodule

// ### upem_top.sv
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "upem_consts.svh"

// Behaviour
// (R01) Count corrected stream bytes, zero to 4095
// (R02) Per-channel 12-bit header/trailer error count
// (R03) Bit 12 set on per-channel counter overflow
// (R04) Four channel instances, chosen by index
// (R05) Per-channel sticky trigger packet error flag
// (R06) Per-channel sticky trigger ack error flag
// (R07) Per-channel sticky stream packet error flag
// (R08) Per-channel sticky control ack error flag
// (R09) Per-channel sticky link test error flag
// (R10) Per-channel sticky heartbeat packet error flag
// (R11) Count uncorrected errors, zero to 4095
// (R12) Bit 2 marks multi-byte stream errors
// (R13) Reads never modify; only reset clears
// (R14) Counter wraps after overflow; bit stays set

module upem_top
	import upem_pkg::*;
#(
	parameter int NCH = `UPEM_NCH
)(
	input  wire logic                     clk,
	input  wire logic                     resetn,
	input  wire logic                     ce,
	input  wire logic [`UPEM_ADDR_W-1:0]  avs_address,
	input  wire logic                     avs_read,
	input  wire logic                     avs_write,
	input  wire logic [`UPEM_DATA_W-1:0]  avs_writedata,
	input  wire logic [`UPEM_BE_W-1:0]    avs_byteenable,
	output logic      [`UPEM_DATA_W-1:0]  avs_readdata,
	output logic      [1:0]               avs_response,
	output logic                          avs_waitrequest,
	input  wire upem_glob_ev_s            glob_ev,
	input  wire upem_chan_ev_s [NCH-1:0]  chan_ev,
	output logic                          irq
);

	// ****************************************************************
	// Channel instances
	// ****************************************************************

	upem_chan_st_s [NCH-1:0] ch_st;
	logic          [NCH-1:0] ch_ovf_evt;
	logic          [NCH-1:0] ch_flag_evt;
	logic          [NCH-1:0] ch_ht_evt;

	// One status block per channel, see (R04)
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		upem_chan u_chan (
			.clk      (clk),
			.resetn   (resetn),
			.ce       (ce),
			.ev       (chan_ev[g]),
			.st       (ch_st[g]),
			.ovf_evt  (ch_ovf_evt[g]),
			.flag_evt (ch_flag_evt[g])
		);
		assign ch_ht_evt[g] = chan_ev[g].ht_err;
	end

	// ****************************************************************
	// State
	// ****************************************************************

	upem_top_st_s st_reg;
	upem_top_st_s st_next;

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Merge one written byte lane group into a narrow field
	function automatic logic [`UPEM_NIRQ-1:0] upem_lane_low(
		input logic [`UPEM_NIRQ-1:0]  old_val,
		input logic [`UPEM_DATA_W-1:0] wd,
		input logic [`UPEM_BE_W-1:0]   be);
		if (be[0]) begin
			upem_lane_low = wd[`UPEM_NIRQ-1:0];
		end else begin
			upem_lane_low = old_val;
		end
	endfunction

	// Select the status of one channel, zero beyond the last one
	function automatic upem_chan_st_s upem_pick(
		input upem_chan_st_s [NCH-1:0] all,
		input logic [`UPEM_SEL_W-1:0]  idx);
		upem_pick = '0;
		for (int i = 0; i < NCH; i++) begin
			if (idx == i[`UPEM_SEL_W-1:0]) begin
				upem_pick = all[i];
			end
		end
	endfunction

	// ****************************************************************
	// Bus request decoding
	// ****************************************************************

	logic          req;
	logic          rd_take;
	logic          wr_take;
	upem_chan_st_s cur;
	logic [`UPEM_DATA_W-1:0] rd_val;
	logic          rd_hit;
	logic [`UPEM_CNT_W-1:0]  unc_view;

	// A request is pending until its answer cycle
	assign req     = avs_read | avs_write;
	assign wr_take = avs_write & st_reg.ack;
	assign rd_take = avs_read & ~st_reg.ack;

	// Status of the channel picked by the index register, see (R04)
	assign cur = upem_pick(ch_st, st_reg.sel);

	// Uncorrected count with the multi-byte marker folded in
	always_comb begin
		unc_view = st_reg.unc_cnt;
		unc_view[`UPEM_MB_BIT] = st_reg.unc_cnt[`UPEM_MB_BIT] | st_reg.mb_seen; // see (R12)
	end

	// Read multiplexer; reads have no side effect, see (R13)
	always_comb begin
		rd_val = `UPEM_RD_ZERO;
		rd_hit = 1'b1;
		if (avs_address == `UPEM_OFS_CORR) begin
			rd_val[`UPEM_CNT_W-1:0] = st_reg.corr_cnt;          // see (R01)
		end else if (avs_address == `UPEM_OFS_UNC) begin
			rd_val[`UPEM_CNT_W-1:0] = unc_view;                 // see (R11)
		end else if (avs_address == `UPEM_OFS_SEL) begin
			rd_val[`UPEM_SEL_W-1:0] = st_reg.sel;
		end else if (avs_address == `UPEM_OFS_HT) begin
			rd_val[`UPEM_CNT_W-1:0] = cur.cnt;                  // see (R02)
			rd_val[`UPEM_HT_OVF_BIT] = cur.ovf;                 // see (R03)
		end else if (avs_address == `UPEM_OFS_FLAGS) begin
			rd_val[`UPEM_NPKT-1:0] = cur.flags;                 // see (R05) see (R10)
		end else if (avs_address == `UPEM_OFS_IRQST) begin
			rd_val[`UPEM_NIRQ-1:0] = st_reg.status;
		end else if (avs_address == `UPEM_OFS_IRQMSK) begin
			rd_val[`UPEM_NIRQ-1:0] = st_reg.mask;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// ****************************************************************
	// Event gathering
	// ****************************************************************

	logic [`UPEM_NIRQ-1:0] evt_vec;

	// Interrupt sources, one per status bit
	always_comb begin
		evt_vec = `UPEM_STS_RST;
		evt_vec[`UPEM_IRQ_CORR] = glob_ev.corrected;
		evt_vec[`UPEM_IRQ_UNC]  = glob_ev.uncorrected | glob_ev.multibyte;
		evt_vec[`UPEM_IRQ_HT]   = |ch_ht_evt;
		evt_vec[`UPEM_IRQ_OVF]  = |ch_ovf_evt;
		evt_vec[`UPEM_IRQ_PKT]  = |ch_flag_evt;
	end

	// ****************************************************************
	// Next state
	// ****************************************************************

	// Counters, bus answer and control registers
	always_comb begin
		st_next = st_reg;

		// Global stream counters hold at full scale
		if (glob_ev.corrected) begin
			st_next.corr_cnt = upem_cnt_inc(st_reg.corr_cnt, 1'b1); // see (R01)
		end
		if (glob_ev.uncorrected) begin
			st_next.unc_cnt = upem_cnt_inc(st_reg.unc_cnt, 1'b1);   // see (R11)
		end
		if (glob_ev.multibyte) begin
			st_next.mb_seen = 1'b1;                                // see (R12)
		end

		// One wait state, then the answer cycle
		st_next.ack = req & ~st_reg.ack;
		if (rd_take) begin
			st_next.rdata = rd_val;
		end
		if (req && !st_reg.ack) begin
			st_next.resp = rd_hit ? `UPEM_RESP_OK : `UPEM_RESP_DEC;
		end

		// Writes land in the answer cycle; counters are read only, see (R13)
		if (wr_take && avs_address == `UPEM_OFS_SEL && avs_byteenable[0]) begin
			st_next.sel = avs_writedata[`UPEM_SEL_W-1:0];           // see (R04)
		end
		if (wr_take && avs_address == `UPEM_OFS_IRQMSK) begin
			st_next.mask = upem_lane_low(st_reg.mask, avs_writedata, avs_byteenable);
		end

		// Sticky status: write one clears, a new event wins
		st_next.status = st_reg.status;
		if (wr_take && avs_address == `UPEM_OFS_IRQST && avs_byteenable[0]) begin
			st_next.status = st_reg.status & ~avs_writedata[`UPEM_NIRQ-1:0];
		end
		st_next.status = st_next.status | evt_vec;
	end

	// ****************************************************************
	// Registers
	// ****************************************************************

	// Whole state in one place, frozen while clock enable is low
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_reg.sel      <= `UPEM_SEL_RST;
			st_reg.mask     <= `UPEM_MSK_RST;
			st_reg.status   <= `UPEM_STS_RST;
			st_reg.corr_cnt <= `UPEM_CNT_ZERO;
			st_reg.unc_cnt  <= `UPEM_CNT_ZERO;
			st_reg.mb_seen  <= 1'b0;
			st_reg.ack      <= 1'b0;
			st_reg.rdata    <= `UPEM_RD_ZERO;
			st_reg.resp     <= `UPEM_RESP_OK;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************

	// Waitrequest stays high until the answer cycle; a frozen clock enable stalls it
	assign avs_waitrequest = req & ~(st_reg.ack & ce);
	assign avs_readdata    = st_reg.rdata;
	assign avs_response    = st_reg.resp;

	// Level interrupt from unmasked sticky bits
	assign irq = |(st_reg.status & st_reg.mask);

endmodule

// ### upem_asserts.sv
`timescale 1ns/100ps
`include "upem_consts.svh"

module upem_asserts
	import upem_pkg::*;
#(
	parameter int NCH = `UPEM_NCH
)(
	input wire logic	clk,
	input wire logic	resetn,
	input wire logic	ce,
	input wire logic [4:0]	avs_address,
	input wire logic	avs_read,
	input wire logic	avs_write,
	input wire logic [31:0]	avs_readdata,
	input wire logic [1:0]	avs_response,
	input wire logic	avs_waitrequest,
	input wire upem_glob_ev_s	glob_ev,
	input wire upem_chan_ev_s [NCH-1:0]	chan_ev,
	input wire logic	irq
);
	// ***
	// Bus and status checks
	// ***
	logic	ans;
	logic	hit;

	// Read answer and mapped offset
	assign ans = avs_read && !avs_waitrequest;
	assign hit = avs_address inside {`UPEM_OFS_CORR, `UPEM_OFS_UNC, `UPEM_OFS_SEL,
		`UPEM_OFS_HT, `UPEM_OFS_FLAGS, `UPEM_OFS_IRQST, `UPEM_OFS_IRQMSK};

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	AST_FIRST_WAIT: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("no wait state");
	AST_ONE_WAIT: assert property (ce && avs_waitrequest |=> !ce || !avs_waitrequest)
		else $error("late answer");
	AST_DEC_ERR: assert property (ans && !hit |-> avs_response == `UPEM_RESP_DEC && avs_readdata == '0)
		else $error("unmapped read accepted");
	AST_DEC_OK: assert property (ans && hit |-> avs_response == `UPEM_RESP_OK)
		else $error("mapped read refused");
	AST_CNT_W: assert property (ans && avs_address inside {0, 4} |-> avs_readdata[31:12] == '0)
		else $error("count too wide");
	AST_HT_W: assert property (ans && avs_address == `UPEM_OFS_HT |-> avs_readdata[31:13] == '0)
		else $error("channel count too wide");
	AST_FLAG_W: assert property (ans && avs_address == `UPEM_OFS_FLAGS |-> avs_readdata[31:6] == '0)
		else $error("flags too wide");
	AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(|glob_ev || |chan_ev || avs_write))
		else $error("irq without cause");
	AST_ANS_HOLD: assert property (!(avs_read || avs_write) |=> $stable({avs_readdata, avs_response}))
		else $error("answer changed while idle");
	AST_CE_FREEZE: assert property (!ce |=> $stable(irq))
		else $error("irq moved while frozen");

	CV_DEC: cover property (ans && !hit);
	CV_IRQ: cover property ($rose(irq));
	CV_OVF: cover property (ans && avs_address == `UPEM_OFS_HT && avs_readdata[12]);
endmodule

// ### upem_cam_model.sv
`timescale 1ns/100ps
`include "upem_consts.svh"

module upem_cam_model
	import upem_pkg::*;
#(
	parameter int NCH = `UPEM_NCH
)(
	input wire logic	clk,
	output upem_glob_ev_s	glob_ev,
	output upem_chan_ev_s [NCH-1:0]	chan_ev
);
	// Link quiet, no errors seen
	initial begin
		glob_ev = '0;
		chan_ev = '0;
	end

	// One-cycle error burst after an idle gap
	task automatic send(input upem_glob_ev_s g, input upem_chan_ev_s [NCH-1:0] c, input int gap);
		repeat (gap + 1) @(posedge clk);
		glob_ev <= g;
		chan_ev <= c;
		@(posedge clk);
		glob_ev <= '0;
		chan_ev <= '0;
	endtask
endmodule

// ### uncorrected_packet_error_monitor_test.sv
`timescale 1ns/100ps
`include "upem_consts.svh"

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
	$display("FAIL %0t got %h want %h", $time, (a), (b)); end end

module uncorrected_packet_error_monitor_test
	import upem_pkg::*;
;
	localparam int NCH = `UPEM_NCH;
	logic	clk;
	logic	resetn;
	logic	ce;
	logic [4:0]	avs_address;
	logic	avs_read;
	logic	avs_write;
	logic [31:0]	avs_writedata;
	logic [3:0]	avs_byteenable;
	logic [31:0]	avs_readdata;
	logic [1:0]	avs_response;
	logic	avs_waitrequest;
	upem_glob_ev_s	glob_ev;
	upem_chan_ev_s [NCH-1:0]	chan_ev;
	logic	irq;
	int	err_total = 0;
	int	checked = 0;
	int	corr;
	int	unc;
	int	ht [NCH];
	logic	mb;
	logic	ovf [NCH];
	logic [5:0]	flg [NCH];
	logic [4:0]	sts;
	logic [4:0]	msk;
	logic [31:0]	d;
	logic [1:0]	r;
	upem_glob_ev_s	g;
	upem_chan_ev_s [NCH-1:0]	c;
	logic [4:0]	offs [7] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18};
	logic [4:0]	bad [3] = '{5'h1c, 5'h02, 5'h1f};

	upem_top #(.NCH(NCH)) i_dut (.clk, .resetn, .ce, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_response, .avs_waitrequest,
		.glob_ev, .chan_ev, .irq);
	upem_cam_model #(.NCH(NCH)) i_cam (.clk, .glob_ev, .chan_ev);

	// ***
	// Tasks
	// ***
	// One transfer, held until waitrequest drops
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd,
		input logic [3:0] be);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= wd;
		avs_byteenable <= be;
		n = 0;
		// Values read right after the edge are those the edge sampled
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		`CHK(avs_waitrequest, 1'b0)
		d = avs_readdata;
		r = avs_response;
		avs_read <= 0;
		avs_write <= 0;
	endtask

	// Expected state after reset
	task automatic clr();
		corr = 0;
		unc = 0;
		mb = 0;
		sts = 0;
		msk = 0;
		ht = '{default: 0};
		ovf = '{default: 0};
		flg = '{default: 0};
	endtask

	// Expected effect of one accepted burst
	task automatic apply();
		if (g.corrected && corr < 4095) corr++;
		if (g.uncorrected && unc < 4095) unc++;
		mb |= g.multibyte;
		sts[1:0] |= {g.uncorrected | g.multibyte, g.corrected};
		for (int i = 0; i < NCH; i++) begin
			sts[4] |= |(c[i].pkt_err & ~flg[i]);
			flg[i] |= c[i].pkt_err;
			sts[2] |= c[i].ht_err;
			ht[i] = (ht[i] + c[i].ht_err) % 4096;
			ovf[i] |= c[i].ht_err && ht[i] == 0;
			sts[3] |= c[i].ht_err && ht[i] == 0;
		end
	endtask

	// Expected read value of an offset
	function automatic logic [31:0] exp_rd(input logic [4:0] a, input int ch);
		case (a)
			`UPEM_OFS_CORR: exp_rd = corr;
			`UPEM_OFS_UNC: exp_rd = unc | (32'(mb) << 2);
			`UPEM_OFS_SEL: exp_rd = ch;
			`UPEM_OFS_HT: exp_rd = 32'({ovf[ch], ht[ch][11:0]});
			`UPEM_OFS_FLAGS: exp_rd = 32'(flg[ch]);
			`UPEM_OFS_IRQST: exp_rd = 32'(sts);
			`UPEM_OFS_IRQMSK: exp_rd = 32'(msk);
			default: exp_rd = '0;
		endcase
	endfunction

	// Read every register for every channel
	task automatic check_all();
		for (int ch = 0; ch < NCH; ch++) begin
			bus(1, `UPEM_OFS_SEL, ch, 4'h1);
			foreach (offs[k]) begin
				bus(0, offs[k], 0, 4'hf);
				`CHK({r, d}, {`UPEM_RESP_OK, exp_rd(offs[k], ch)})
			end
		end
		@(negedge clk);
		`CHK(irq, |(sts & msk))
	endtask

	// Counts, verdict, end of run
	task automatic final_report();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ***
	// Processes
	// ***
	// Clock
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end

	// Watchdog
	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		$display("FAIL %0t watchdog", $time);
		final_report();
	end

	// Main sequence
	initial begin
		void'($urandom(78613));
		resetn = 0;
		ce = 1;
		avs_address = 0;
		avs_read = 0;
		avs_write = 0;
		avs_writedata = 0;
		avs_byteenable = 0;
		clr();
		repeat (20) @(posedge clk);
		resetn <= 1;
		check_all();
		// Unmapped offsets, read-only write, lane 0 disabled
		foreach (bad[k]) begin
			bus(1, bad[k], '1, 4'hf);
			`CHK(r, `UPEM_RESP_DEC)
			bus(0, bad[k], 0, 4'hf);
			`CHK({r, d}, {`UPEM_RESP_DEC, `UPEM_RD_ZERO})
		end
		bus(1, `UPEM_OFS_CORR, '1, 4'hf);
		`CHK(r, `UPEM_RESP_OK)
		bus(1, `UPEM_OFS_SEL, 1, 4'he);
		bus(0, `UPEM_OFS_SEL, 0, 4'hf);
		`CHK(d, exp_rd(`UPEM_OFS_SEL, NCH - 1))
		msk = 5'($urandom);
		bus(1, `UPEM_OFS_IRQMSK, msk, 4'h1);
		// Random bursts, some while frozen
		repeat (80) begin
			g = $bits(g)'($urandom);
			c = $bits(c)'($urandom & $urandom & $urandom);
			ce <= ($urandom % 6) != 0;
			i_cam.send(g, c, $urandom % 3);
			if (ce)
				apply();
		end
		ce <= 1;
		check_all();
		// Long run: global counts saturate, channel count wraps
		g = '{1'b1, 1'b1, 1'b0};
		c = '0;
		c[2].ht_err = 1;
		repeat (4100) begin
			i_cam.send(g, c, 0);
			apply();
		end
		check_all();
		// Interrupt: unmask, partial clear, full clear, masked event
		msk = 5'h1f;
		bus(1, `UPEM_OFS_IRQMSK, msk, 4'h1);
		bus(1, `UPEM_OFS_IRQST, 5'h15, 4'h1);
		sts &= ~5'h15;
		check_all();
		bus(1, `UPEM_OFS_IRQST, '1, 4'h1);
		sts = 0;
		msk = 5'h1e;
		bus(1, `UPEM_OFS_IRQMSK, msk, 4'h1);
		g = '{1'b1, 1'b0, 1'b0};
		c = '0;
		i_cam.send(g, c, 0);
		apply();
		check_all();
		// Reset in mid-run clears everything
		@(posedge clk);
		resetn <= 0;
		repeat (3) @(posedge clk);
		resetn <= 1;
		clr();
		check_all();
		final_report();
	end
endmodule

bind upem_top upem_asserts #(.NCH(NCH)) i_chk (.clk, .resetn, .ce, .avs_address, .avs_read,
	.avs_write, .avs_readdata, .avs_response, .avs_waitrequest, .glob_ev, .chan_ev, .irq);
